// file: verilog/flash_host_pkg.sv
// Purpose: Shared constants for the parallel flash status controller.
// Assumes: 25 MHz pclk, byte-wide flash data bus, APB register access.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package flash_host_pkg;
   // APB register map.
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ADDR = 8'h04;
   localparam logic [7:0] OFF_WDATA = 8'h08;
   localparam logic [7:0] OFF_RESULT = 8'h0C;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // Control register fields.
   localparam int CTRL_OP_LO = 0;
   localparam int CTRL_BOUND_BIT = 3;
   localparam int CTRL_PROG_LIMIT_BIT = 4;
   localparam int CTRL_PE_ENABLE_BIT = 8;
   // Operation codes written to the control register.
   localparam logic [1:0] OP_NONE = 2'h0;
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ = 2'h2;
   localparam logic [1:0] OP_POLL = 2'h3;
   // Result register fields.
   localparam int RES_READ_LO = 0;
   localparam int RES_STATUS_LO = 8;
   localparam int RES_BUSY_BIT = 16;
   localparam int RES_TIMEOUT_BIT = 17;
   localparam int RES_ERROR_BIT = 18;
   // Flash status byte layout.
   localparam int READY_BIT = 7;
   localparam int ERASE_SUSP_BIT = 6;
   localparam logic [7:0] STATUS_MASK = 8'hFE;
   localparam logic [7:0] ERROR_MASK = 8'h3A;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_READ_STATUS = 8'h70;
   // Timing.
   localparam int CLK_MHZ = 25;
   localparam int PROG_SUSP_MAX_US = 20;
   localparam int ERASE_SUSP_MAX_US = 25;
   localparam int TIMER_W = 12;
   localparam logic [11:0] PROG_SUSP_CYCLES = 12'(PROG_SUSP_MAX_US * CLK_MHZ);
   localparam logic [11:0] ERASE_SUSP_CYCLES = 12'(ERASE_SUSP_MAX_US * CLK_MHZ);
   localparam int SYNC_CYCLES = 4;
   typedef enum logic [4:0]
   {
      ST_IDLE = 5'b00001,
      ST_WSTROBE = 5'b00010,
      ST_WRECOVER = 5'b00100,
      ST_RSTROBE = 5'b01000,
      ST_RGAP = 5'b10000
   } state_t;
endpackage

// file: verilog/pin_sync.sv
// Purpose: Three-stage synchroniser for a group of pin inputs.
// Assumes: Inputs are asynchronous to pclk.
// Notes: A bit changes at the output only once stages two and three agree.
`timescale 1ns/1ns
module pin_sync #(
   parameter int WIDTH = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] pin_in,
   output logic [WIDTH-1:0] sync_q
);
   logic [WIDTH-1:0] s1_q;
   logic [WIDTH-1:0] s2_q;
   logic [WIDTH-1:0] s3_q;
   wire [WIDTH-1:0] agree_w = ~(s2_q ^ s3_q);
   wire [WIDTH-1:0] sync_d = (agree_w & s3_q) | (~agree_w & sync_q);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         sync_q <= '0;
      end
      else
      begin
         s1_q <= pin_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         sync_q <= sync_d;
      end
   end
endmodule

// file: verilog/flash_status_host.sv
// Purpose: Host-side controller that drives a parallel flash and polls its status byte.
// Assumes: Byte mode; the flash keeps its own status rules; APB software interface.
// Notes: Polling toggles output enable between reads so each read shows fresh status.
//
// Summary of operation
// - Fresh status appears per output-enable toggle or chip reselect; host toggles.
// - Host polls ready until 1, then checks the error flags.
// - Erase-suspended bit 6 is valid only while ready reads 1.
// - Erase-error clears only by clear-status or reset; host keeps its error summary until software sends clear-status.
// - Host masks reserved status bit 0.
`timescale 1ns/1ns
module flash_status_host
   import flash_host_pkg::*;
#(
   parameter int ADDR_W = 23,
   parameter int STROBE_CYCLES = 3
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata_q,
   output logic pready_q,
   output logic pslverr_q,
   output logic [ADDR_W-1:0] flash_addr_q,
   output logic [7:0] flash_dq_out_q,
   output logic flash_dq_oe_q,
   input wire logic [7:0] flash_dq_in,
   output logic flash_ce_n_q,
   output logic flash_oe_n_q,
   output logic flash_we_n_q,
   output logic program_erase_enable_q
);
   localparam logic [TIMER_W-1:0] STROBE_LOAD = TIMER_W'(STROBE_CYCLES - 1);
   localparam logic [TIMER_W-1:0] READ_LOAD = TIMER_W'(STROBE_CYCLES + SYNC_CYCLES - 1);

   state_t state_q;
   logic [TIMER_W-1:0] timer_q;
   logic [TIMER_W-1:0] poll_cnt_q;
   logic [ADDR_W-1:0] addr_reg_q;
   logic [7:0] wdata_q;
   logic bound_q;
   logic prog_limit_q;
   logic poll_mode_q;
   logic [7:0] read_byte_q;
   logic [7:0] status_q;
   logic timeout_q;
   logic error_any_q;
   logic busy_q;
   logic [7:0] dq_sync;

   pin_sync #(.WIDTH(8)) u_dq_sync (
      .pclk(pclk),
      .presetn(presetn),
      .pin_in(flash_dq_in),
      .sync_q(dq_sync)
   );

   // APB decode; the slave answers one cycle after setup, with no wait states.
   wire setup_w = psel & ~penable & ~pready_q;
   wire access_w = psel & penable & pready_q;
   wire hit_ctrl_w = (paddr == OFF_CTRL);
   wire hit_addr_w = (paddr == OFF_ADDR);
   wire hit_wdata_w = (paddr == OFF_WDATA);
   wire hit_result_w = (paddr == OFF_RESULT);
   wire hit_w = hit_ctrl_w | hit_addr_w | hit_wdata_w | hit_result_w;
   wire wr_ctrl_w = access_w & pwrite & hit_ctrl_w;
   wire [1:0] op_w = pwdata[CTRL_OP_LO +: 2];
   // Orders arriving while an operation runs are dropped; software checks busy first.
   wire start_w = wr_ctrl_w & (state_q == ST_IDLE) & (op_w != OP_NONE);
   wire [31:0] ctrl_rd_w = {23'h00_0000, program_erase_enable_q, 3'h0, prog_limit_q,
                            bound_q, 3'h0};
   wire [31:0] result_rd_w = {13'h0000, error_any_q, timeout_q, busy_q,
                              status_q, read_byte_q};
   wire [31:0] rd_mux_w = hit_ctrl_w ? ctrl_rd_w :
                          hit_addr_w ? 32'(addr_reg_q) :
                          hit_wdata_w ? {24'h00_0000, wdata_q} :
                          hit_result_w ? result_rd_w : CTRL_RESET;

   // Capture decisions at the end of a read strobe.
   wire [7:0] masked_w = dq_sync & STATUS_MASK;
   wire ready_w = dq_sync[READY_BIT];
   wire [TIMER_W-1:0] poll_limit_w = prog_limit_q ? PROG_SUSP_CYCLES : ERASE_SUSP_CYCLES;
   // Suspend latency bounds the wait when software asks for a bounded poll.
   wire limit_hit_w = bound_q & (poll_cnt_q >= poll_limit_w);
   wire timer_done_w = (timer_q == '0);
   wire repoll_w = poll_mode_q & ~ready_w & ~limit_hit_w;
   wire clear_cmd_w = (wdata_q == CMD_CLEAR_STATUS);

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= CTRL_RESET;
         addr_reg_q <= '0;
         wdata_q <= 8'h00;
         bound_q <= 1'b0;
         prog_limit_q <= 1'b0;
         program_erase_enable_q <= 1'b0;
      end
      else
      begin
         pready_q <= setup_w;
         if (setup_w)
         begin
            prdata_q <= rd_mux_w;
            pslverr_q <= ~hit_w;
         end
         if (access_w & pwrite & hit_addr_w)
            addr_reg_q <= pwdata[ADDR_W-1:0];
         if (access_w & pwrite & hit_wdata_w)
            wdata_q <= pwdata[7:0];
         if (wr_ctrl_w)
         begin
            bound_q <= pwdata[CTRL_BOUND_BIT];
            prog_limit_q <= pwdata[CTRL_PROG_LIMIT_BIT];
            program_erase_enable_q <= pwdata[CTRL_PE_ENABLE_BIT];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ST_IDLE;
         timer_q <= '0;
         poll_cnt_q <= '0;
         poll_mode_q <= 1'b0;
         busy_q <= 1'b0;
         flash_addr_q <= '0;
         flash_dq_out_q <= 8'h00;
         flash_dq_oe_q <= 1'b0;
         flash_ce_n_q <= 1'b1;
         flash_oe_n_q <= 1'b1;
         flash_we_n_q <= 1'b1;
         read_byte_q <= 8'h00;
         status_q <= 8'h00;
         timeout_q <= 1'b0;
         error_any_q <= 1'b0;
      end
      else
      begin
         timer_q <= timer_done_w ? timer_q : timer_q - 1'b1;
         if (poll_mode_q & bound_q & ~limit_hit_w)
            poll_cnt_q <= poll_cnt_q + 1'b1;
         unique case (state_q)
            ST_IDLE:
            begin
               if (start_w)
               begin
                  busy_q <= 1'b1;
                  timeout_q <= 1'b0;
                  poll_cnt_q <= '0;
                  poll_mode_q <= (op_w == OP_POLL);
                  flash_addr_q <= addr_reg_q;
                  flash_ce_n_q <= 1'b0;
                  if (op_w == OP_WRITE)
                  begin
                     // Command writes such as read-status put the flash in status mode.
                     flash_dq_out_q <= wdata_q;
                     flash_dq_oe_q <= 1'b1;
                     flash_we_n_q <= 1'b0;
                     timer_q <= STROBE_LOAD;
                     state_q <= ST_WSTROBE;
                  end
                  else
                  begin
                     // Status reads ignore the address, so the held address is harmless.
                     flash_oe_n_q <= 1'b0;
                     timer_q <= READ_LOAD;
                     state_q <= ST_RSTROBE;
                  end
               end
            end
            ST_WSTROBE:
            begin
               if (timer_done_w)
               begin
                  flash_we_n_q <= 1'b1;
                  timer_q <= STROBE_LOAD;
                  state_q <= ST_WRECOVER;
               end
            end
            ST_WRECOVER:
            begin
               if (timer_done_w)
               begin
                  flash_ce_n_q <= 1'b1;
                  flash_dq_oe_q <= 1'b0;
                  busy_q <= 1'b0;
                  state_q <= ST_IDLE;
                  // Only clear-status wipes the cached error summary.
                  if (clear_cmd_w)
                     error_any_q <= 1'b0;
               end
            end
            ST_RSTROBE:
            begin
               if (timer_done_w)
               begin
                  read_byte_q <= dq_sync;
                  flash_oe_n_q <= 1'b1;
                  if (poll_mode_q)
                     status_q <= masked_w;
                  if (repoll_w)
                  begin
                     // Deselect between polls so the flash refreshes its status.
                     flash_ce_n_q <= 1'b1;
                     timer_q <= STROBE_LOAD;
                     state_q <= ST_RGAP;
                  end
                  else
                  begin
                     flash_ce_n_q <= 1'b1;
                     busy_q <= 1'b0;
                     poll_mode_q <= 1'b0;
                     state_q <= ST_IDLE;
                     timeout_q <= poll_mode_q & ~ready_w;
                     // Error bits are trusted only once ready reads 1.
                     if (poll_mode_q & ready_w & |(dq_sync & ERROR_MASK))
                        error_any_q <= 1'b1;
                  end
               end
            end
            ST_RGAP:
            begin
               if (timer_done_w)
               begin
                  flash_ce_n_q <= 1'b0;
                  flash_oe_n_q <= 1'b0;
                  timer_q <= READ_LOAD;
                  state_q <= ST_RSTROBE;
               end
            end
         endcase
      end
   end

   sequence write_strobe_s;
      !flash_we_n_q [*3];
   endsequence
   a_strobe_exclusive: assert property (@(posedge pclk) disable iff (!presetn)
      !(!flash_we_n_q && !flash_oe_n_q))
      else $error("write and output enable both active");
   a_drive_no_read: assert property (@(posedge pclk) disable iff (!presetn)
      flash_dq_oe_q |-> flash_oe_n_q)
      else $error("host drives data while flash outputs");
   a_strobe_needs_ce: assert property (@(posedge pclk) disable iff (!presetn)
      (!flash_we_n_q || !flash_oe_n_q) |-> !flash_ce_n_q)
      else $error("strobe without chip enable");
   a_write_width: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(flash_we_n_q) |-> write_strobe_s ##1 flash_we_n_q)
      else $error("write strobe width wrong");
   a_gap_toggles_oe: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_RGAP) |-> flash_oe_n_q && flash_ce_n_q)
      else $error("output enable not released between polls");
   a_poll_ends_ready: assert property (@(posedge pclk) disable iff (!presetn)
      ($fell(busy_q) && $past(poll_mode_q) && !timeout_q) |-> status_q[READY_BIT])
      else $error("poll finished without ready");
   a_mask_reserved: assert property (@(posedge pclk) disable iff (!presetn)
      status_q[0] == 1'b0)
      else $error("reserved status bit not masked");
   a_apb_answer: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pready_q) |=> pready_q ##1 !pready_q)
      else $error("APB answer not one cycle");
   a_clear_errors: assert property (@(posedge pclk) disable iff (!presetn)
      (state_q == ST_WRECOVER && timer_done_w && clear_cmd_w) |=> !error_any_q)
      else $error("clear-status did not clear error summary");
endmodule

// file: verification/flash_dev_model.sv
// Purpose: Behavioural parallel flash that answers commands and status reads.
// Assumes: Byte mode; address bit 16 marks a protected block, bit 17 failing cells.
// Notes: Operation and suspend times are short parameters, not worst case.
`timescale 1ns/1ns
module flash_dev_model #(
   // Byte programming takes the effective buffered time per byte.
   parameter int PROG_NS = 6000,
   parameter int ERASE_NS = 30000,
   parameter int SUSP_NS = 1000
) (
   input wire logic ce_n,
   input wire logic oe_n,
   input wire logic we_n,
   input wire logic enable,
   input wire logic [22:0] addr,
   input wire logic [7:0] dq_in,
   output logic [7:0] dq_out
);
   logic [7:0] sr = 8'h80;
   logic [7:0] shown = 8'h80;
   logic [7:0] last = 8'h00;
   logic [7:0] setup = 8'h00;
   logic [7:0] pend = 8'h00;
   logic stat_mode = 1'b0;
   logic busy = 1'b0;
   logic erasing = 1'b0;
   logic tgl = 1'b0;
   logic id_mode = 1'b0;
   int left = 0;
   int susp = 0;
   // Protection area: two lock bytes, then bytes 0 to F, one byte at each address.
   wire [4:0] prot_idx = addr[4:0] - 5'd2;
   wire [7:0] prot_w = (addr[4:1] == 4'h0) ? 8'hC3 : {4'h5, prot_idx[3:0]};
   wire [7:0] array_w = (id_mode && addr[8]) ? prot_w : addr[7:0];
   // A released bus shows the inverse of the last byte so a stale value never passes.
   assign dq_out = (!ce_n && !oe_n) ? (stat_mode ? shown : array_w) : ~last;
   always @(negedge oe_n or negedge ce_n)
   begin
      tgl = ~tgl;
      shown = busy ? {1'b0, ~last[6:0]} : {sr[7:1], tgl};
   end
   always @(posedge oe_n)
      last = stat_mode ? shown : array_w;
   always @(posedge we_n)
   begin
      if (!ce_n && setup != 8'h00)
      begin
         pend = (setup == 8'h20) ? 8'h20 : 8'h10;
         if (setup == 8'h20 && dq_in != 8'hD0)
            pend = 8'h30;
         else if (!enable)
            pend = pend | 8'h08;
         else if (addr[16])
            pend = pend | 8'h02;
         else if (!addr[17])
            pend = 8'h00;
         erasing = setup == 8'h20;
         left = erasing ? ERASE_NS : PROG_NS;
         busy = 1'b1;
         stat_mode = 1'b1;
         setup = 8'h00;
      end
      else if (!ce_n)
      begin
         id_mode = dq_in == 8'h90;
         case (dq_in)
            8'h20, 8'h40: setup = dq_in;
            8'h50: sr = sr & 8'hC5;
            8'h70: stat_mode = 1'b1;
            8'hB0: susp = busy ? SUSP_NS : 0;
            8'hD0:
            begin
               busy = sr[6] | sr[2];
               sr = sr & 8'hBB;
               stat_mode = 1'b1;
            end
            default: stat_mode = 1'b0;
         endcase
      end
   end
   always #40
   begin
      if (busy && susp > 0)
      begin
         susp = susp - 40;
         busy = susp > 0;
         sr = busy ? sr : sr | (erasing ? 8'h40 : 8'h04);
      end
      else if (busy)
      begin
         left = left - 40;
         busy = left > 0;
         sr = busy ? sr : sr | pend;
      end
   end
endmodule

// file: verification/flash_status_host_tb_top.sv
// Purpose: Self-checking bench for the flash status host controller.
// Assumes: The flash model finishes every operation within a few tens of microseconds.
// Notes: Each case runs an operation, polls, rechecks the sticky flags, then clears.
`timescale 1ns/1ns
module flash_status_host_tb_top;
   import flash_host_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata_q;
   logic pready_q;
   logic pslverr_q;
   logic [22:0] flash_addr_q;
   logic [7:0] flash_dq_out_q;
   logic flash_dq_oe_q;
   logic [7:0] dev_dq;
   logic [7:0] flash_dq_in;
   logic flash_ce_n_q;
   logic flash_oe_n_q;
   logic flash_we_n_q;
   logic program_erase_enable_q;
   int miscompares = 0;
   int tests_run = 0;
   logic [31:0] r;
   logic e;
   logic [31:0] t;
   logic [31:0] ctl = 32'h0000_0100;
   // Setup, confirm, flags (bit 0 enable, 1 protected, 2 failing cells), expected status.
   logic [31:0] cases [9] = '{32'h405A_0180, 32'h405A_0098, 32'h405A_0392,
      32'h405A_0590, 32'h20D0_0180, 32'h20D0_00A8, 32'h20D0_03A2, 32'h20D0_05A0,
      32'h20FF_01B0};
   // Protection byte address low bits and the byte the model holds there.
   logic [15:0] prot_cases [3] = '{16'h01C3, 16'h0250, 16'h115F};
   assign flash_dq_in = flash_dq_oe_q ? flash_dq_out_q : dev_dq;
   flash_status_host flash_status_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata_q(prdata_q), .pready_q(pready_q), .pslverr_q(pslverr_q),
      .flash_addr_q(flash_addr_q), .flash_dq_out_q(flash_dq_out_q),
      .flash_dq_oe_q(flash_dq_oe_q), .flash_dq_in(flash_dq_in),
      .flash_ce_n_q(flash_ce_n_q), .flash_oe_n_q(flash_oe_n_q),
      .flash_we_n_q(flash_we_n_q), .program_erase_enable_q(program_erase_enable_q));
   flash_dev_model flash_dev_model_i (.ce_n(flash_ce_n_q), .oe_n(flash_oe_n_q),
      .we_n(flash_we_n_q), .enable(program_erase_enable_q), .addr(flash_addr_q),
      .dq_in(flash_dq_in), .dq_out(dev_dq));
   always #20 pclk = ~pclk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_of_test();
      $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do
         @(posedge pclk);
      while (pready_q !== 1'b1);
      r = prdata_q;
      e = pslverr_q;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wait_idle();
      do
         apb(1'b0, OFF_RESULT, 32'h0000_0000);
      while (r[RES_BUSY_BIT] !== 1'b0);
   endtask
   task automatic run_op(input logic [1:0] op);
      apb(1'b1, OFF_CTRL, ctl | 32'(op));
      wait_idle();
   endtask
   task automatic cmd(input logic [7:0] d);
      apb(1'b1, OFF_WDATA, {24'h00_0000, d});
      run_op(OP_WRITE);
   endtask
   initial
   begin
      repeat (60000) @(posedge pclk);
      miscompares++;
      end_of_test();
   end
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      chk(flash_ce_n_q, 1'b1);
      apb(1'b0, OFF_CTRL, 32'h0000_0000);
      chk(r, CTRL_RESET);
      apb(1'b0, 8'h10, 32'h0000_0000);
      chk(r, CTRL_RESET);
      chk(32'(e), 32'h0000_0001);
      for (int i = 0; i < 9; i++)
      begin
         t = cases[i];
         ctl = 32'(t[8]) << CTRL_PE_ENABLE_BIT;
         cmd(t[31:24]);
         apb(1'b1, OFF_ADDR, {14'h0000, t[10:9], 16'h0000});
         cmd(t[23:16]);
         run_op(OP_POLL);
         chk(r[15:8], t[7:0]);
         chk(r[RES_ERROR_BIT], t[7:0] != 8'h80);
         cmd(8'h70);
         run_op(OP_POLL);
         chk(r[15:8], t[7:0]);
         cmd(8'h50);
         run_op(OP_POLL);
         chk(r[18:8], 11'h080);
      end
      ctl = 32'h0000_0100;
      apb(1'b1, OFF_ADDR, 32'h007F_FF00);
      cmd(8'h70);
      run_op(OP_READ);
      chk(r[7:0] & 8'hFE, 8'h80);
      cmd(8'hFF);
      apb(1'b1, OFF_ADDR, 32'h0000_0033);
      run_op(OP_READ);
      chk(r[7:0], 8'h33);
      cmd(8'h90);
      for (int k = 0; k < 3; k++)
      begin
         apb(1'b1, OFF_ADDR, 32'h0000_0100 | 32'(prot_cases[k][15:8]));
         run_op(OP_READ);
         chk(r[7:0], prot_cases[k][7:0]);
      end
      for (int j = 0; j < 2; j++)
      begin
         cmd(j ? 8'h40 : 8'h20);
         cmd(j ? 8'h5A : 8'hD0);
         cmd(8'hB0);
         run_op(OP_POLL);
         chk(r[15:8], j ? 8'h84 : 8'hC0);
         cmd(8'hD0);
         run_op(OP_POLL);
         chk(r[15:8], 8'h80);
      end
      // Both poll bounds are shorter than the model's erase, so each must time out.
      for (int k = 0; k < 2; k++)
      begin
         cmd(8'h20);
         cmd(8'hD0);
         apb(1'b1, OFF_CTRL, ctl | (k ? 32'h0000_0018 : 32'h0000_0008) | 32'(OP_POLL));
         wait_idle();
         chk(r[RES_TIMEOUT_BIT], 1'b1);
         chk(r[15:8] & 8'h80, 8'h00);
         run_op(OP_POLL);
         chk(r[15:8], 8'h80);
      end
      end_of_test();
   end
endmodule
